// ### inc/sram_host_pkg.sv
// Package for the asynchronous static memory host controller.
// Assumes a 50 MHz system clock; all times below are in ns.
package sram_host_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned LANE_W        = 8;

  // Faster grade figures
  localparam int unsigned READ_CYCLE_MIN_NS         = 150;
  localparam int unsigned ADDRESS_ACCESS_DELAY_NS   = 150;
  localparam int unsigned WRITE_PULSE_MIN_NS        = 100;
  localparam int unsigned WRITE_DATA_LEAD_TIME_NS   = 60;
  localparam int unsigned STROBE_TO_OUTPUT_FLOAT_NS = 40;
  localparam int unsigned STROBE_HIGH_TO_LOWZ_NS    = 5;
  localparam int unsigned DESELECT_TO_RETENTION_NS  = 0;
  localparam int unsigned RETENTION_RECOVERY_NS     = READ_CYCLE_MIN_NS;

  // Least times round up to whole cycles, never below one
  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  localparam int unsigned READ_CYCLES     = ns_to_cycles(ADDRESS_ACCESS_DELAY_NS);
  localparam int unsigned READ_CYCLE_MIN  = ns_to_cycles(READ_CYCLE_MIN_NS);
  localparam int unsigned WRITE_CYCLES    = ns_to_cycles(WRITE_PULSE_MIN_NS);
  localparam int unsigned WRITE_OE_CYCLES =
    ns_to_cycles(STROBE_TO_OUTPUT_FLOAT_NS + STROBE_HIGH_TO_LOWZ_NS + WRITE_PULSE_MIN_NS);
  localparam int unsigned DATA_LEAD_CYCLES = ns_to_cycles(WRITE_DATA_LEAD_TIME_NS);
  localparam int unsigned RECOVERY_CYCLES  = ns_to_cycles(RETENTION_RECOVERY_NS);
  localparam int unsigned RETENTION_LEAD_CYCLES = ns_to_cycles(DESELECT_TO_RETENTION_NS);
  localparam int unsigned CNT_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_READ    = 3'b001,
    ST_WRITE   = 3'b010,
    ST_GAP     = 3'b011,
    ST_RETAIN  = 3'b100,
    ST_RECOVER = 3'b101
  } host_state_e;

  typedef struct packed {
    logic                write;
    logic [1:0]          lane_n;  // [1] upper, [0] lower, active low
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } host_req_s;

  typedef struct packed {
    logic                chip_select_n;
    logic                write_strobe_n;
    logic                output_gate_n;
    logic                upper_lane_enable_n;
    logic                lower_lane_enable_n;
  } sram_ctl_s;

  localparam sram_ctl_s CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage : sram_host_pkg

// ### hw/sram_host_ctrl.sv
// Host controller driving an asynchronous 64K x 16 static memory with byte lanes.
// Assumes user requests synchronous to clk_in; memory pins routed straight out.
`timescale 1ns/1ps

// Notes on behaviour
// - Address changes only with strobe, lanes or select inactive.
// - Host drives data only with gate high, as soon as one cycle (20 ns) after a read's gate rises.
// - Gate held high during write, so strobe is not stretched by float plus re-enable delay.
// - Successive reads spaced by at least the read cycle time.
// - Strobe low at least 100 ns, data valid 60 ns before end.
// - Select high before retention; wait a read cycle after recovery.
// - Address valid no later than select or lanes falling.
module sram_host_ctrl
  import sram_host_pkg::*;
(
  input  wire logic                              clk_in,
  input  wire logic                              rst_b_in,
  input  wire logic                              req_valid_in,
  input  wire sram_host_pkg::host_req_s          req_in,
  input  wire logic                              retain_in,
  output logic                                   req_ready_out,
  output logic                                   rdata_valid_out,
  output logic [sram_host_pkg::DATA_W-1:0]       rdata_out,
  output logic                                   retained_out,
  output logic [sram_host_pkg::ADDR_W-1:0]       word_address_out,
  output sram_host_pkg::sram_ctl_s               ctl_out,
  input  wire logic [sram_host_pkg::DATA_W-1:0]  data_in,
  output logic [sram_host_pkg::DATA_W-1:0]       data_out,
  output logic [sram_host_pkg::DATA_W-1:0]       data_oe_out
);
  import sram_host_pkg::*;

  host_state_e             state_reg;
  logic [CNT_W-1:0]        cnt_reg;
  logic                    wr_gate_reg;
  logic [1:0]              lane_n_reg;

  // Lane mask to per-bit output enable
  function automatic logic [DATA_W-1:0] lane_bits(input logic [1:0] lane_n);
    return {{LANE_W{~lane_n[1]}}, {LANE_W{~lane_n[0]}}};
  endfunction : lane_bits

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      wr_gate_reg <= 1'b0;
      lane_n_reg  <= 2'b11;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (retain_in) begin
            state_reg <= ST_RETAIN;
          end else if (req_valid_in && (req_in.lane_n != 2'b11)) begin
            lane_n_reg  <= req_in.lane_n;
            wr_gate_reg <= 1'b0;
            if (req_in.write) begin
              state_reg <= ST_WRITE;
              cnt_reg   <= CNT_W'(WRITE_CYCLES - 1);
            end else begin
              state_reg <= ST_READ;
              cnt_reg   <= CNT_W'(READ_CYCLE_MIN - 1);
            end
          end
        end
        ST_READ: begin
          if (cnt_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_WRITE: begin
          if (cnt_reg == '0) begin
            state_reg <= ST_GAP;
            cnt_reg   <= CNT_W'(READ_CYCLE_MIN - WRITE_CYCLES);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_GAP: begin
          if (cnt_reg <= 1) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_RETAIN: begin
          if (!retain_in) begin
            state_reg <= ST_RECOVER;
            cnt_reg   <= CNT_W'(RECOVERY_CYCLES - 1);
          end
        end
        ST_RECOVER: begin
          if (cnt_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory pins; address latched only while idle with all strobes high
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_address_out <= '0;
      ctl_out          <= CTL_IDLE;
      data_out         <= '0;
      data_oe_out      <= '0;
    end else begin
      ctl_out     <= CTL_IDLE;
      data_oe_out <= '0;
      if (state_reg == ST_IDLE && !retain_in && req_valid_in && (req_in.lane_n != 2'b11)) begin
        word_address_out <= req_in.addr;
        data_out         <= req_in.wdata;
        ctl_out.chip_select_n       <= 1'b0;
        ctl_out.upper_lane_enable_n <= req_in.lane_n[1];
        ctl_out.lower_lane_enable_n <= req_in.lane_n[0];
        if (req_in.write) begin
          // Gate held high so the memory never drives during the write
          ctl_out.write_strobe_n <= 1'b0;
          data_oe_out            <= lane_bits(req_in.lane_n);
        end else begin
          ctl_out.output_gate_n <= 1'b0;
        end
      end else if (state_reg == ST_READ && cnt_reg != '0) begin
        ctl_out.chip_select_n       <= 1'b0;
        ctl_out.output_gate_n       <= 1'b0;
        ctl_out.upper_lane_enable_n <= lane_n_reg[1];
        ctl_out.lower_lane_enable_n <= lane_n_reg[0];
      end else if (state_reg == ST_WRITE && cnt_reg != '0) begin
        ctl_out.chip_select_n       <= 1'b0;
        ctl_out.write_strobe_n      <= 1'b0;
        ctl_out.upper_lane_enable_n <= lane_n_reg[1];
        ctl_out.lower_lane_enable_n <= lane_n_reg[0];
        data_oe_out                 <= lane_bits(lane_n_reg);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // User side status
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_ready_out   <= 1'b0;
      rdata_valid_out <= 1'b0;
      rdata_out       <= '0;
      retained_out    <= 1'b0;
    end else begin
      req_ready_out   <= (state_reg == ST_IDLE) && !(req_valid_in || retain_in);
      retained_out    <= (state_reg == ST_RETAIN);
      rdata_valid_out <= 1'b0;
      // Sample at the start of the last selected cycle, 140 ns after select, short of the 150 ns access delay
      if (state_reg == ST_READ && cnt_reg == CNT_W'(1)) begin
        rdata_out       <= data_in & lane_bits(lane_n_reg);
        rdata_valid_out <= 1'b1;
      end
    end
  end

endmodule : sram_host_ctrl

// ### bench/sram_host_ctrl_asserts.sv
// Pin timing checker for the static memory host controller.
// Assumes package figures at 50 MHz; bound to every controller.
`timescale 1ns/1ps
module sram_host_ctrl_asserts
  import sram_host_pkg::*;
(
  input wire logic                         clk_in,
  input wire logic                         rst_b_in,
  input wire logic                         rdata_valid_out,
  input wire logic                         retained_out,
  input wire logic [sram_host_pkg::ADDR_W-1:0] word_address_out,
  input wire sram_host_pkg::sram_ctl_s     ctl_out,
  input wire logic [sram_host_pkg::DATA_W-1:0] data_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic quiet;
  assign quiet = ctl_out.write_strobe_n || ctl_out.chip_select_n
    || (ctl_out.upper_lane_enable_n && ctl_out.lower_lane_enable_n);
  chk_addr_quiet: assert property (!$stable(word_address_out) |-> $past(quiet) || quiet)
    else $error("address moved in a write");
  chk_bus_turn: assert property (|data_oe_out |-> ctl_out.output_gate_n)
    else $error("host drove against memory");
  chk_read_hold: assert property ($fell(ctl_out.output_gate_n) |->
    (!ctl_out.output_gate_n)[*8] ##1 ctl_out.output_gate_n)
    else $error("read pulse length");
  chk_read_answer: assert property ($fell(ctl_out.output_gate_n) |->
    (!rdata_valid_out)[*7] ##1 rdata_valid_out)
    else $error("read answer late");
  chk_write_pulse: assert property ($fell(ctl_out.write_strobe_n) |->
    (!ctl_out.write_strobe_n)[*5] ##1 ctl_out.write_strobe_n)
    else $error("write pulse length");
  chk_write_data: assert property (!ctl_out.write_strobe_n |-> ctl_out.output_gate_n && |data_oe_out)
    else $error("write data or gate");
  chk_upper_lane: assert property (|data_oe_out[15:8] |->
    !ctl_out.upper_lane_enable_n && !ctl_out.write_strobe_n)
    else $error("upper byte driven");
  chk_lower_lane: assert property (|data_oe_out[7:0] |->
    !ctl_out.lower_lane_enable_n && !ctl_out.write_strobe_n)
    else $error("lower byte driven");
  chk_retain_sel: assert property (retained_out |-> ctl_out.chip_select_n)
    else $error("selected in retention");
  chk_recover_wait: assert property ($fell(retained_out) |-> ctl_out.chip_select_n[*8])
    else $error("recovery too short");
endmodule : sram_host_ctrl_asserts
bind sram_host_ctrl sram_host_ctrl_asserts chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .rdata_valid_out(rdata_valid_out), .retained_out(retained_out),
  .word_address_out(word_address_out), .ctl_out(ctl_out), .data_oe_out(data_oe_out));

// ### bench/sram_mem_model.sv
// Behavioural 64K x 16 static memory with byte lanes.
// Assumes host pins straight from the controller; no clock.
`timescale 1ns/1ps
module sram_mem_model
  import sram_host_pkg::*;
(
  input wire logic [15:0]              word_address_in,
  input wire sram_host_pkg::sram_ctl_s ctl_in,
  input wire logic [15:0]              host_data_in,
  input wire logic [15:0]              host_oe_in,
  output logic [15:0]                  bus_out
);
  logic [15:0] mem [0:65535];
  logic        rd;
  logic        wr;
  logic [15:0] lane_m;
  logic [15:0] drv;
  assign lane_m = {{8{!ctl_in.upper_lane_enable_n}}, {8{!ctl_in.lower_lane_enable_n}}};
  assign rd = !ctl_in.chip_select_n && !ctl_in.output_gate_n && ctl_in.write_strobe_n;
  assign wr = !ctl_in.chip_select_n && !ctl_in.write_strobe_n && |lane_m;
  assign drv = rd ? lane_m : 16'h0000;
  always @(wr or word_address_in or host_data_in or lane_m) begin
    if (wr) begin
      mem[word_address_in] = (mem[word_address_in] & ~lane_m) | (host_data_in & lane_m);
    end
  end
  // Floating bits show a moving pattern, never a stale value
  assign bus_out = (host_oe_in & host_data_in) | (~host_oe_in & drv & mem[word_address_in])
    | (~host_oe_in & ~drv & (word_address_in ^ 16'h5a5a));
endmodule : sram_mem_model

// ### bench/tb.sv
// Self-checking bench for the static memory host controller.
// Assumes the behavioural memory model on the far side of the pins.
`timescale 1ns/1ps
module tb;
  import sram_host_pkg::*;
  logic              clk_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic              req_valid_in = 1'b0;
  host_req_s         req_in = '0;
  logic              retain_in = 1'b0;
  logic              req_ready_out, rdata_valid_out, retained_out;
  logic [DATA_W-1:0] rdata_out, data_in, data_out, data_oe_out;
  logic [ADDR_W-1:0] word_address_out;
  sram_ctl_s         ctl_out;
  int                err_count = 0;
  int                checks_done = 0;
  always #10 clk_in = ~clk_in;
  sram_host_ctrl dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .retain_in(retain_in), .req_ready_out(req_ready_out), .rdata_valid_out(rdata_valid_out),
    .rdata_out(rdata_out), .retained_out(retained_out), .word_address_out(word_address_out),
    .ctl_out(ctl_out), .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out));
  sram_mem_model mem (.word_address_in(word_address_out), .ctl_in(ctl_out), .host_data_in(data_out),
    .host_oe_in(data_oe_out), .bus_out(data_in));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Ready only means idle while no request waits, so wait first, then hold over one take edge
  task automatic issue(input logic w, input logic [1:0] ln, input logic [15:0] a, input logic [15:0] d);
    int n;
    for (n = 0; n < 40 && req_ready_out !== 1'b1; n++) @(negedge clk_in);
    check({15'h0000, req_ready_out}, 16'h0001, "idle before request");
    req_in = '{w, ln, a, d};
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
  endtask : issue
  task automatic read_chk(input logic [1:0] ln, input logic [15:0] a, input logic [15:0] exp);
    int n;
    issue(1'b0, ln, a, 16'h0000);
    for (n = 0; n < 20 && rdata_valid_out !== 1'b1; n++) @(negedge clk_in);
    check({15'h0000, rdata_valid_out}, 16'h0001, "read answer");
    check(rdata_out, exp, "read data");
  endtask : read_chk
  ////////////////////////////////////////////////////////////////
  task automatic t_bytes;
    issue(1'b1, 2'b00, 16'h0010, 16'h1234);
    issue(1'b1, 2'b00, 16'hffff, 16'h5566);
    issue(1'b1, 2'b10, 16'hffff, 16'h77ab);
    issue(1'b1, 2'b01, 16'hffff, 16'hcd88);
    read_chk(2'b10, 16'hffff, 16'h00ab);
    read_chk(2'b01, 16'hffff, 16'hcd00);
    read_chk(2'b00, 16'hffff, 16'hcdab);
    read_chk(2'b00, 16'h0010, 16'h1234);
    $display("test bytes done");
  endtask : t_bytes
  task automatic t_ignore;
    req_in = '{1'b1, 2'b11, 16'h0010, 16'hdead};
    req_valid_in = 1'b1;
    repeat (4) @(negedge clk_in);
    check({15'h0000, ctl_out.chip_select_n}, 16'h0001, "no lanes stays idle");
    req_valid_in = 1'b0;
    @(negedge clk_in);
    read_chk(2'b00, 16'h0010, 16'h1234);
    $display("test ignore done");
  endtask : t_ignore
  task automatic t_retain;
    retain_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check({15'h0000, retained_out}, 16'h0001, "retention entered");
    check({15'h0000, ctl_out.chip_select_n}, 16'h0001, "deselected");
    retain_in = 1'b0;
    @(negedge clk_in);
    read_chk(2'b00, 16'hffff, 16'hcdab);
    $display("test retain done");
  endtask : t_retain
  initial begin
    repeat (5) @(negedge clk_in);
    rst_b_in = 1'b1;
    @(negedge clk_in);
    t_bytes;
    t_ignore;
    t_retain;
    give_verdict;
  end
  // About 120 cycles of traffic; generous margin
  initial begin
    #50000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule : tb
